// ===== pmap_cfg.svh
`ifndef PMAP_CFG_SVH
`define PMAP_CFG_SVH
`define PMAP_RS_ADDR_PW   3'h0
`define PMAP_RS_PAL       3'h1
`define PMAP_RS_MASK      3'h2
`define PMAP_RS_ADDR_PR   3'h3
`define PMAP_RS_ADDR_OW   3'h4
`define PMAP_RS_OVL       3'h5
`define PMAP_RS_CMD       3'h6
`define PMAP_RS_ADDR_OR   3'h7
`define PMAP_PH_RED       2'h0
`define PMAP_PH_GRN       2'h1
`define PMAP_PH_BLU       2'h2
`define PMAP_CMD_W8_BIT   1
`define PMAP_CMD_RST      8'h00
`define PMAP_MASK_RST     8'hff
`define PMAP_IDX_ONE      8'h01
`define PMAP_OVL_ZERO     4'h0
`define PMAP_SIX_MASK     8'h3f
`endif

// ===== pmap_pkg.sv
package pmap_pkg;
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] grn;
    logic [7:0] blu;
  } pmap_rgb_t;
  typedef enum logic {PMAP_MODE_WRITE, PMAP_MODE_READ} pmap_mode_t;
endpackage

// ===== pmap_port.sv
`timescale 1ns/1ps
`include "pmap_cfg.svh"
module pmap_port (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       wr_n,
  input  wire logic       rd_n,
  input  wire logic [2:0] register_select,
  input  wire logic [7:0] data_in,
  output logic [7:0]      data_out,
  output logic            data_oe,
  output logic [7:0]      control_output_pins,
  output logic [7:0]      pixel_mask
);
  // Pin synchronisers: two stages, only stage two is read by logic
  logic       wr_s1_ff;
  logic       wr_s2_ff;
  logic       rd_s1_ff;
  logic       rd_s2_ff;
  logic [7:0] d_s1_ff;
  logic [7:0] d_s2_ff;
  logic [2:0] rs_s1_ff;
  logic [2:0] rs_s2_ff;
  logic       wr_q_ff;
  logic       rd_q_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_s1_ff <= 1'b1;
      wr_s2_ff <= 1'b1;
      rd_s1_ff <= 1'b1;
      rd_s2_ff <= 1'b1;
      d_s1_ff  <= 8'h00;
      d_s2_ff  <= 8'h00;
      rs_s1_ff <= 3'h0;
      rs_s2_ff <= 3'h0;
      wr_q_ff  <= 1'b1;
      rd_q_ff  <= 1'b1;
    end else begin
      wr_s1_ff <= wr_n;
      wr_s2_ff <= wr_s1_ff;
      rd_s1_ff <= rd_n;
      rd_s2_ff <= rd_s1_ff;
      d_s1_ff  <= data_in;
      d_s2_ff  <= d_s1_ff;
      rs_s1_ff <= register_select;
      rs_s2_ff <= rs_s1_ff;
      wr_q_ff  <= wr_s2_ff;
      rd_q_ff  <= rd_s2_ff;
    end
  end

  // Strobe levels and edges after synchronising
  wire       wr_lvl  = wr_s2_ff;
  wire       rd_lvl  = rd_s2_ff;
  wire       wr_fall = wr_q_ff & ~wr_lvl;
  wire       wr_rise = ~wr_q_ff & wr_lvl;
  wire       rd_fall = rd_q_ff & ~rd_lvl;
  wire       rd_rise = ~rd_q_ff & rd_lvl;
  wire [7:0] wdata   = d_s2_ff;

  // Latched select and state
  logic [2:0]         rs_ff;
  logic [7:0]         index_ff, cmd_ff, mask_ff;
  logic [1:0]         phase_ff;
  pmap_pkg::pmap_mode_t mode_ff;
  pmap_pkg::pmap_rgb_t  hold_ff, wcol_ff;
  logic [7:0]         pal_r [256], pal_g [256], pal_b [256];
  logic [7:0]         ovl_r [16], ovl_g [16], ovl_b [16];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) rs_ff <= 3'h0;
    else if (wr_fall || rd_fall) rs_ff <= rs_s2_ff;
  end

  wire six_bit   = ~cmd_ff[`PMAP_CMD_W8_BIT];
  wire [7:0] cdat = six_bit ? (wdata & `PMAP_SIX_MASK) : wdata;
  wire is_addr_w = (rs_ff == `PMAP_RS_ADDR_PW) || (rs_ff == `PMAP_RS_ADDR_OW);
  wire is_addr_r = (rs_ff == `PMAP_RS_ADDR_PR) || (rs_ff == `PMAP_RS_ADDR_OR);
  wire is_addr   = is_addr_w || is_addr_r;
  wire is_ovl_sel = rs_ff[2];
  wire is_col    = (rs_ff == `PMAP_RS_PAL) || (rs_ff == `PMAP_RS_OVL);
  wire [3:0] onib = index_ff[3:0];
  wire ovl_ok    = onib != `PMAP_OVL_ZERO;
  wire wr_done   = wr_rise;
  wire col_wr    = wr_done && is_col;
  wire col_rd    = rd_rise && is_col;
  wire blue_wr   = col_wr && phase_ff == `PMAP_PH_BLU;
  wire blue_rd   = col_rd && phase_ff == `PMAP_PH_BLU;
  wire addr_load = wr_done && is_addr;
  wire preload   = addr_load && is_addr_r;
  wire [7:0] lidx = addr_load ? wdata : index_ff;
  wire [3:0] lnib = lidx[3:0];
  wire pal_side  = addr_load ? ~rs_ff[2] : ~is_ovl_sel;
  pmap_pkg::pmap_rgb_t fetch;
  assign fetch = pal_side ? '{pal_r[lidx], pal_g[lidx], pal_b[lidx]}
                          : '{ovl_r[lnib], ovl_g[lnib], ovl_b[lnib]};
  wire [7:0] nxt_index = lidx + `PMAP_IDX_ONE;
  wire [1:0] nxt_phase = (phase_ff == `PMAP_PH_BLU) ? `PMAP_PH_RED : phase_ff + 2'h1;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      index_ff <= 8'h00;
      phase_ff <= `PMAP_PH_RED;
      mode_ff  <= pmap_pkg::PMAP_MODE_WRITE;
      cmd_ff   <= `PMAP_CMD_RST;
      mask_ff  <= `PMAP_MASK_RST;
      hold_ff  <= '0;
      wcol_ff  <= '0;
    end else begin
      if (addr_load) begin
        phase_ff <= `PMAP_PH_RED;
        mode_ff  <= is_addr_r ? pmap_pkg::PMAP_MODE_READ : pmap_pkg::PMAP_MODE_WRITE;
        index_ff <= preload ? nxt_index : wdata;
        if (preload) hold_ff <= fetch;
      end else if (col_wr) begin
        phase_ff <= nxt_phase;
        case (phase_ff)
          `PMAP_PH_RED: wcol_ff.red <= cdat;
          `PMAP_PH_GRN: wcol_ff.grn <= cdat;
          default: begin
            wcol_ff.blu <= cdat;
            index_ff <= nxt_index;
          end
        endcase
      end else if (col_rd) begin
        phase_ff <= nxt_phase;
        if (blue_rd) begin
          hold_ff  <= fetch;
          index_ff <= nxt_index;
        end
      end else if (wr_done && rs_ff == `PMAP_RS_CMD) cmd_ff <= wdata;
      else if (wr_done && rs_ff == `PMAP_RS_MASK) mask_ff <= wdata;
    end
  end

  // Entry store after blue write
  always_ff @(posedge clk) begin
    if (blue_wr && !is_ovl_sel) begin
      pal_r[index_ff] <= wcol_ff.red;
      pal_g[index_ff] <= wcol_ff.grn;
      pal_b[index_ff] <= cdat;
    end
    if (blue_wr && is_ovl_sel && ovl_ok) begin
      ovl_r[onib] <= wcol_ff.red;
      ovl_g[onib] <= wcol_ff.grn;
      ovl_b[onib] <= cdat;
    end
  end

  // A strobe edge hands the fresh select code to the read path
  wire [2:0] rsel_code = (wr_fall || rd_fall) ? rs_s2_ff : rs_ff;
  wire       sel_col   = (rsel_code == `PMAP_RS_PAL) || (rsel_code == `PMAP_RS_OVL);

  logic [7:0] rsel;
  always_comb begin
    case (rsel_code)
      `PMAP_RS_PAL, `PMAP_RS_OVL: begin
        case (phase_ff)
          `PMAP_PH_RED: rsel = hold_ff.red;
          `PMAP_PH_GRN: rsel = hold_ff.grn;
          default:      rsel = hold_ff.blu;
        endcase
        if (six_bit) rsel = rsel & `PMAP_SIX_MASK;
      end
      `PMAP_RS_MASK: rsel = mask_ff;
      `PMAP_RS_CMD:  rsel = cmd_ff;
      default:       rsel = index_ff;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_out            <= 8'h00;
      data_oe             <= 1'b0;
      control_output_pins <= `PMAP_CMD_RST;
      pixel_mask          <= `PMAP_MASK_RST;
    end else begin
      data_oe  <= ~rd_lvl && wr_lvl;
      data_out <= rsel;
      control_output_pins <= cmd_ff;
      pixel_mask <= mask_ff;
    end
  end

  // Bus side
  a_rs_latch: assert property (@(posedge clk) disable iff (rst)
    (wr_fall || rd_fall) |=> rs_ff == $past(rs_s2_ff)) else $error("select not latched");
  a_drive_read: assert property (@(posedge clk) disable iff (rst)
    (!rd_lvl && wr_lvl) |=> data_oe) else $error("bus not driven");
  a_oe_idle: assert property (@(posedge clk) disable iff (rst)
    rd_lvl |=> !data_oe) else $error("bus driven without read");
  a_red_capture: assert property (@(posedge clk) disable iff (rst)
    (col_wr && !six_bit && phase_ff == `PMAP_PH_RED) |=> wcol_ff.red == $past(d_s2_ff)) else $error("data not taken");
  a_six_write: assert property (@(posedge clk) disable iff (rst)
    (col_wr && six_bit && phase_ff == `PMAP_PH_RED) |=> wcol_ff.red[7:6] == 2'b00) else $error("top bits stored");
  a_six_read: assert property (@(posedge clk) disable iff (rst)
    (six_bit && sel_col) |=> data_out[7:6] == 2'b00) else $error("top bits set");
  a_ctrl_mirror: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> control_output_pins == $past(cmd_ff)) else $error("control mismatch");
  a_mask_mirror: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> pixel_mask == $past(mask_ff)) else $error("mask output mismatch");
  // Index and phase
  a_idx_blue_adv: assert property (@(posedge clk) disable iff (rst)
    blue_wr |=> index_ff == $past(index_ff) + `PMAP_IDX_ONE) else $error("index not advanced");
  a_idx_rd_adv: assert property (@(posedge clk) disable iff (rst)
    blue_rd |=> index_ff == $past(index_ff) + `PMAP_IDX_ONE) else $error("index not advanced on read");
  a_preload_adv: assert property (@(posedge clk) disable iff (rst)
    preload |=> index_ff == $past(wdata) + `PMAP_IDX_ONE) else $error("preload index wrong");
  a_wrap_ff: assert property (@(posedge clk) disable iff (rst)
    (blue_wr && index_ff == 8'hff) |=> index_ff == 8'h00) else $error("no wrap");
  a_phase_clear: assert property (@(posedge clk) disable iff (rst)
    addr_load |=> phase_ff == `PMAP_PH_RED) else $error("phase not cleared");
  a_phase_step: assert property (@(posedge clk) disable iff (rst)
    (col_wr && phase_ff == `PMAP_PH_RED) |=> phase_ff == `PMAP_PH_GRN) else $error("phase not advanced");
  a_phase_range: assert property (@(posedge clk) disable iff (rst)
    phase_ff != 2'h3) else $error("phase out of range");
  a_idx_read_keep: assert property (@(posedge clk) disable iff (rst)
    (rd_rise && is_addr) |=> $stable(index_ff) && $stable(phase_ff) && $stable(mode_ff)) else $error("index read changed state");
  a_cmd_no_adv: assert property (@(posedge clk) disable iff (rst)
    (wr_done && rs_ff == `PMAP_RS_CMD) |=> $stable(index_ff) && $stable(phase_ff)) else $error("cmd write moved index");
  a_mask_no_adv: assert property (@(posedge clk) disable iff (rst)
    (wr_done && rs_ff == `PMAP_RS_MASK) |=> $stable(index_ff) && $stable(phase_ff)) else $error("mask write moved index");
endmodule // pmap_port

// ===== pmap_host.sv
`timescale 1ns/1ps
module pmap_host (
  input  wire logic       clk,
  output logic            wr_n,
  output logic            rd_n,
  output logic [2:0]      register_select,
  output logic [7:0]      data_in,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe
);
  logic [7:0] drv;
  logic       drv_en;
  // Released bus shows data_out while data_oe is high, else inverse of last byte
  assign data_in = drv_en ? drv : (data_oe ? data_out : ~drv);
  initial begin
    {wr_n, rd_n, register_select, drv, drv_en} = {2'h3, 12'h000};
  end
  task automatic access(input logic wr, input logic [2:0] rs, input logic [7:0] d);
    @(negedge clk);
    {register_select, drv, drv_en} = {rs, d, wr};
    repeat (3) @(negedge clk);
    if (wr) wr_n = 1'b0;
    else rd_n = 1'b0;
    repeat (6) @(negedge clk);
    {wr_n, rd_n} = 2'h3;
    repeat (5) @(negedge clk);
    drv_en = 1'b0;
  endtask
endmodule // pmap_host

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
  logic       clk;
  logic       rst;
  logic       six;
  logic       oe_p;
  logic [7:0] cmd;
  logic [7:0] v;
  logic [7:0] mk;
  logic [7:0] ctl_p;
  logic [7:0] mem [0:1][0:255][0:2];
  logic [7:0] rd_q [$];
  logic [7:0] ctl_q [$];
  int         miscompares;
  int         check_count;
  int         cyc;
  wire        wr_n, rd_n, oe;
  wire  [2:0] rs;
  wire  [7:0] din, dout, ctl, pmask;
  wire  [7:0] msk = six ? 8'h3f : 8'hff;
  initial clk = 1'b0;
  always #50 clk = ~clk;
  pmap_port i_pmap_port (.clk(clk), .rst(rst), .wr_n(wr_n), .rd_n(rd_n), .register_select(rs),
    .data_in(din), .data_out(dout), .data_oe(oe), .control_output_pins(ctl), .pixel_mask(pmask));
  pmap_host i_pmap_host (.clk(clk), .wr_n(wr_n), .rd_n(rd_n), .register_select(rs),
    .data_in(din), .data_out(dout), .data_oe(oe));
  task cmp_rd(input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t exp %h got %h", $time, e, g);
    end
  endtask
  task cmp_ctl(input logic [7:0] e, input logic [7:0] g);
    cmp_rd(e, g);
  endtask
  task final_report;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(negedge clk) begin
    if (oe === 1'b1 && oe_p !== 1'b1 && rd_q.size() > 0) cmp_rd(rd_q.pop_front(), dout);
    if (ctl !== ctl_p && ctl_q.size() > 0) cmp_ctl(ctl_q.pop_front(), ctl);
    oe_p <= oe;
    ctl_p <= ctl;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end
  task wr(input logic [2:0] r, input logic [7:0] d);
    i_pmap_host.access(1'b1, r, d);
  endtask
  task rd(input logic [2:0] r, input logic [7:0] e);
    rd_q.push_back(e);
    i_pmap_host.access(1'b0, r, 8'h00);
  endtask
  task cmd_w(input logic [7:0] d);
    if (d !== cmd) ctl_q.push_back(d);
    cmd = d;
    six = !d[1];
    wr(3'h6, d);
  endtask
  function automatic logic [7:0] ea(input logic ov, input logic [7:0] a);
    return ov ? {4'h0, a[3:0]} : a;
  endfunction
  task rd3(input logic ov, input logic [7:0] a);
    for (int c = 0; c < 3; c++) rd(ov ? 3'h5 : 3'h1, mem[ov][ea(ov, a)][c] & msk);
  endtask
  task pal_w(input logic ov, input logic [7:0] a, input int n);
    wr(ov ? 3'h4 : 3'h0, a);
    for (int i = 0; i < 3 * n; i++) begin
      v = 8'($urandom);
      mem[ov][ea(ov, a)][i % 3] = v & msk;
      wr(ov ? 3'h5 : 3'h1, v);
      if (i % 3 == 2) a++;
    end
  endtask
  task pal_r(input logic ov, input logic [7:0] a, input int n);
    wr(ov ? 3'h7 : 3'h3, a);
    for (int i = 0; i < n; i++) rd3(ov, a + 8'(i));
  endtask
  initial begin
    rst = 1'b1;
    six = 1'b1;
    cmd = 8'h00;
    v = 8'($urandom(93));
    repeat (5) @(negedge clk);
    cmp_ctl(8'h00, ctl);
    cmp_rd(8'hff, pmask);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    cmd_w(8'($urandom) | 8'h02);
    rd(3'h6, cmd);
    mk = 8'($urandom);
    wr(3'h2, mk);
    cmp_rd(mk, pmask);
    rd(3'h2, mk);
    pal_w(1'b0, 8'hfe, 3);
    pal_r(1'b0, 8'hfe, 2);
    rd(3'h3, 8'h01);
    rd3(1'b0, 8'h00);
    wr(3'h0, 8'h40);
    wr(3'h1, 8'h5a);
    pal_w(1'b0, 8'h40, 1);
    wr(3'h3, 8'h40);
    rd(3'h1, mem[0][8'h40][0]);
    rd(3'h2, mk);
    rd(3'h3, 8'h41);
    wr(3'h6, cmd);
    rd(3'h1, mem[0][8'h40][1]);
    rd(3'h1, mem[0][8'h40][2]);
    pal_w(1'b1, 8'h1e, 2);
    pal_r(1'b1, 8'h3e, 2);
    cmd_w(cmd & 8'hfd);
    pal_r(1'b0, 8'hfe, 1);
    pal_w(1'b0, 8'h05, 1);
    pal_r(1'b0, 8'h05, 1);
    repeat (10) @(negedge clk);
    cmp_rd(8'h00, 8'(rd_q.size() + ctl_q.size()));
    final_report();
  end
endmodule // testbench
